// ==== hdl/bpt_regs.sv ====
/*
 * Boot pulse, temperature and vector magnitude register block with serial access.
 * Assumes sensor samples arrive on the core clock; strap and hibernate are raw pins.
 */
// Functional notes
// - strap low: boot pulse on pin one, or two
// - strap low, enabled: one short boot pulse
// - strap high: one long active-low open-drain pulse
// - after power-on or hibernate, strap-low pulse is active high
// - soft reset keeps polarity, driver and pin map
// - host access refused until boot completes
// - temperature is 8-bit two's complement
// - register zero means 25 degrees
// - temperature refreshed every output rate cycle
// - magnitude updated only while enabled
// - magnitude register read clears sample-ready flag
// - magnitude byte order selectable, little-endian default
// - low register holds magnitude bits 7..0 (bits 11..4 when order bit set)
// - high register bits 3..0 hold bits 11..8 (bits 7..4 hold bits 3..0 when order bit set)
// - boot-done flag set, held until reset events
// - new data latched with sample-ready flag
`timescale 1ns/1ps
module bpt_regs #(
	parameter int BOOT_SEQ_CYC_P = bpt_pkg::BOOT_SEQ_CYC,
	parameter int BOOT_SHORT_CYC_P = bpt_pkg::BOOT_SHORT_CYC,
	parameter int BOOT_LONG_CYC_P = bpt_pkg::BOOT_LONG_CYC
) (
	// core clock and reset
	input wire logic clock,
	input wire logic reset,
	// serial link
	input wire logic spi_sclk,
	input wire logic spi_csb_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe_n,
	// straps and power state
	input wire logic boot_mode_strap,
	input wire logic hibernate,
	// sensor front end
	input wire logic sample_strobe,
	input wire logic [7:0] temp_celsius,
	input wire logic [11:0] magnitude_sample,
	// interrupt pins
	output logic first_interrupt_pin_o,
	output logic first_interrupt_pin_oe_n,
	output logic second_interrupt_pin_o,
	output logic second_interrupt_pin_oe_n,
	// status
	output logic boot_done
);
	import bpt_pkg::*;

	typedef struct packed {
		logic strap_s1;
		logic strap_s2;
		logic hib_s1;
		logic hib_s2;
		logic ws1;
		logic ws2;
		logic wprev;
		logic rs1;
		logic rs2;
		logic rprev;
		bpt_boot_e state;
		logic [CNT_W-1:0] cnt;
		logic strap;
		logic boot_done;
		logic pol;
		logic ppod;
		logic route2;
		logic boot_ien;
		logic byte_order;
		logic mag_en;
		logic [7:0] temp;
		logic [11:0] mag;
		logic drdy;
		logic [7:0] rdata;
		logic rvalid;
		logic p1_o;
		logic p1_oe_n;
		logic p2_o;
		logic p2_oe_n;
	} bpt_core_s;

	bpt_core_s q_q;
	bpt_core_s q_d;
	logic wr_evt;
	logic rd_evt;
	logic soft_evt;
	logic restart;

	bpt_link_if lnk ();

	// serial frame logic on the host clock
	bpt_spi_link u_link (
		.spi_sclk(spi_sclk),
		.spi_csb_n(spi_csb_n),
		.spi_mosi(spi_mosi),
		.spi_miso_o(spi_miso_o),
		.spi_miso_oe_n(spi_miso_oe_n),
		.lnk(lnk)
	);

	// pin level for a pulse: polarity 0 is active high; open drain only pulls low
	function automatic logic [1:0] pin_drive(input logic active, input logic pol,
			input logic od);
		logic want;
		want = active ? ~pol : pol;
		if (od) begin
			pin_drive = {1'b0, want};
		end else begin
			pin_drive = {want, 1'b0};
		end
	endfunction : pin_drive

	// register read decode, returns the byte only; validity is set by the caller
	function automatic logic [7:0] reg_read(input bpt_core_s s, input logic [6:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == A_STATUS) begin
			r[ST_BOOT_BIT] = s.boot_done;
			r[ST_DRDY_BIT] = s.drdy;
		end else if (a == A_TEMP) begin
			r = s.temp;
		end else if (a == A_MAG_LO) begin
			r = s.byte_order ? s.mag[11:4] : s.mag[7:0];
		end else if (a == A_MAG_HI) begin
			r = s.byte_order ? {s.mag[3:0], 4'h0} : {4'h0, s.mag[11:8]};
		end else if (a == A_CFG_TWO) begin
			r[C2_ORDER_BIT] = s.byte_order;
		end else if (a == A_CFG_FOUR) begin
			r[C4_POL_BIT] = s.pol;
			r[C4_OD_BIT] = s.ppod;
		end else if (a == A_CFG_FIVE) begin
			r[C5_MAG_BIT] = s.mag_en;
		end else if (a == A_PIN_MAP) begin
			r[PM_ROUTE_BIT] = s.route2;
		end else if (a == A_INT_EN) begin
			r[IE_BOOT_BIT] = s.boot_ien;
		end
		return r;
	endfunction : reg_read

	// request edges from the synchronised link levels
	assign wr_evt = q_q.ws2 & ~q_q.wprev;
	assign rd_evt = q_q.rs2 & ~q_q.rprev;
	assign soft_evt = wr_evt & q_q.boot_done & (lnk.addr == A_SOFT_RST) & lnk.wdata[SR_GO_BIT];
	assign restart = soft_evt | q_q.hib_s2;

	// next state of the whole core
	always_comb begin
		q_d = q_q;
		q_d.strap_s1 = boot_mode_strap;
		q_d.strap_s2 = q_q.strap_s1;
		q_d.hib_s1 = hibernate;
		q_d.hib_s2 = q_q.hib_s1;
		q_d.ws1 = lnk.wreq;
		q_d.ws2 = q_q.ws1;
		q_d.wprev = q_q.ws2;
		q_d.rs1 = lnk.rreq;
		q_d.rs2 = q_q.rs1;
		q_d.rprev = q_q.rs2;

		// boot sequencer
		case (q_q.state)
			BPT_BOOTING: begin
				if (q_q.cnt == CNT_W'(BOOT_SEQ_CYC_P - 1)) begin
					q_d.cnt = '0;
					q_d.strap = q_q.strap_s2; // strap caught after release, at boot end
					q_d.boot_done = 1'b1;
					if (q_q.strap_s2 || q_q.boot_ien) begin
						q_d.state = BPT_PULSE;
					end else begin
						q_d.state = BPT_READY;
					end
				end else begin
					q_d.cnt = q_q.cnt + CNT_W'(1);
				end
			end
			BPT_PULSE: begin
				// long width for strap high, short otherwise
				if ((q_q.strap && q_q.cnt == CNT_W'(BOOT_LONG_CYC_P - 1)) ||
						(!q_q.strap && q_q.cnt == CNT_W'(BOOT_SHORT_CYC_P - 1))) begin
					q_d.state = BPT_READY;
					q_d.cnt = '0;
				end else begin
					q_d.cnt = q_q.cnt + CNT_W'(1);
				end
			end
			BPT_READY: begin
				q_d.cnt = '0; // ready only leaves through a restart, so one pulse
			end
			default: begin
				q_d.state = BPT_BOOTING;
				q_d.cnt = '0;
			end
		endcase

		// host writes, ignored while booting
		if (wr_evt && q_q.boot_done) begin
			if (lnk.addr == A_CFG_TWO) begin
				q_d.byte_order = lnk.wdata[C2_ORDER_BIT];
			end else if (lnk.addr == A_CFG_FOUR) begin
				q_d.pol = lnk.wdata[C4_POL_BIT];
				q_d.ppod = lnk.wdata[C4_OD_BIT];
			end else if (lnk.addr == A_CFG_FIVE) begin
				q_d.mag_en = lnk.wdata[C5_MAG_BIT];
			end else if (lnk.addr == A_PIN_MAP) begin
				q_d.route2 = lnk.wdata[PM_ROUTE_BIT];
			end else if (lnk.addr == A_INT_EN) begin
				q_d.boot_ien = lnk.wdata[IE_BOOT_BIT];
			end
		end

		// host reads: answer held for the link until the next read
		if (rd_evt) begin
			q_d.rvalid = q_q.boot_done;
			q_d.rdata = q_q.boot_done ? reg_read(q_q, lnk.addr) : 8'h00;
			if (q_q.boot_done && (lnk.addr == A_MAG_LO || lnk.addr == A_MAG_HI)) begin
				q_d.drdy = 1'b0;
			end
		end

		// sample latch comes after the read clear so a same-cycle set wins
		if (sample_strobe) begin
			q_d.temp = temp_celsius - TEMP_REF_C;
			if (q_q.mag_en) begin
				q_d.mag = magnitude_sample;
			end
			q_d.drdy = 1'b1;
		end

		// soft reset restarts boot but keeps the pin settings
		if (restart) begin
			q_d.state = BPT_BOOTING;
			q_d.cnt = '0;
			q_d.boot_done = 1'b0;
			q_d.drdy = 1'b0;
			q_d.mag = '0;
			q_d.temp = '0;
			q_d.byte_order = ORDER_RST;
			q_d.mag_en = MAGEN_RST;
			q_d.rvalid = 1'b0;
		end
		// hibernate loses the pin settings too; soft reset does not touch them
		if (q_q.hib_s2) begin
			q_d.pol = POL_RST;
			q_d.ppod = OD_RST;
			q_d.route2 = ROUTE_RST;
			q_d.boot_ien = IEN_RST;
		end

		// registered pin drive from the next state
		if (q_d.strap && q_d.state == BPT_PULSE) begin
			{q_d.p2_o, q_d.p2_oe_n} = pin_drive(1'b1, 1'b1, 1'b1);
			{q_d.p1_o, q_d.p1_oe_n} = pin_drive(1'b0, q_d.pol, q_d.ppod);
		end else if (q_d.strap) begin
			{q_d.p2_o, q_d.p2_oe_n} = pin_drive(1'b0, 1'b1, 1'b1);
			{q_d.p1_o, q_d.p1_oe_n} = pin_drive(1'b0, q_d.pol, q_d.ppod);
		end else begin
			{q_d.p1_o, q_d.p1_oe_n} = pin_drive(q_d.state == BPT_PULSE && !q_d.route2,
				q_d.pol, q_d.ppod);
			{q_d.p2_o, q_d.p2_oe_n} = pin_drive(q_d.state == BPT_PULSE && q_d.route2,
				q_d.pol, q_d.ppod);
		end
	end

	// single state register; pins released in reset
	always_ff @(posedge clock) begin
		if (reset) begin
			q_q <= '0;
			q_q.pol <= POL_RST;
			q_q.ppod <= OD_RST;
			q_q.route2 <= ROUTE_RST;
			q_q.boot_ien <= IEN_RST;
			q_q.byte_order <= ORDER_RST;
			q_q.mag_en <= MAGEN_RST;
			q_q.p1_oe_n <= PIN_OE_N_RST;
			q_q.p2_oe_n <= PIN_OE_N_RST;
		end else begin
			q_q <= q_d;
		end
	end

	// outputs
	assign lnk.rdata = q_q.rdata;
	assign lnk.rvalid = q_q.rvalid;
	assign first_interrupt_pin_o = q_q.p1_o;
	assign first_interrupt_pin_oe_n = q_q.p1_oe_n;
	assign second_interrupt_pin_o = q_q.p2_o;
	assign second_interrupt_pin_oe_n = q_q.p2_oe_n;
	assign boot_done = q_q.boot_done;

	// helper: cycles spent in the current pulse, for width checks
	logic [CNT_W-1:0] plen_q;
	logic [3:0] mag_hi;
	logic [7:0] mag_lo;
	assign mag_hi = q_q.mag[11:8];
	assign mag_lo = q_q.mag[7:0];
	always_ff @(posedge clock) begin
		if (reset || q_q.state != BPT_PULSE) begin
			plen_q <= '0;
		end else begin
			plen_q <= plen_q + CNT_W'(1);
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	chk_route_pin_level: assert property (
		(q_q.state == BPT_PULSE && !q_q.strap && !q_q.ppod) |->
			((q_q.route2 ? second_interrupt_pin_o : first_interrupt_pin_o) == !q_q.pol) &&
			((q_q.route2 ? first_interrupt_pin_o : second_interrupt_pin_o) == q_q.pol))
		else $error("boot pulse on wrong pin or level");

	chk_short_width: assert property (
		(q_q.state == BPT_PULSE && q_d.state != BPT_PULSE && !q_q.strap && !restart) |->
			plen_q == CNT_W'(BOOT_SHORT_CYC_P - 1))
		else $error("short boot pulse width wrong");

	chk_pulse_once: assert property (
		(q_q.state == BPT_READY && !restart) |=> q_q.state == BPT_READY)
		else $error("second boot pulse without restart");

	chk_long_width: assert property (
		(q_q.state == BPT_PULSE && q_d.state != BPT_PULSE && q_q.strap && !restart) |->
			plen_q == CNT_W'(BOOT_LONG_CYC_P - 1))
		else $error("long boot pulse width wrong");

	chk_long_pin_low: assert property (
		(q_q.state == BPT_PULSE && q_q.strap) |->
			!second_interrupt_pin_o && !second_interrupt_pin_oe_n)
		else $error("strap high pulse not pulled low");

	chk_pol_default: assert property (
		q_q.hib_s2 ##1 !q_q.hib_s2 |-> !q_q.pol && !q_q.boot_done)
		else $error("polarity not active high after hibernate");

	chk_soft_keep: assert property (
		(soft_evt && !q_q.hib_s2) |=>
			$stable(q_q.pol) && $stable(q_q.ppod) && $stable(q_q.route2) &&
			q_q.state == BPT_BOOTING && !q_q.boot_done)
		else $error("soft reset disturbed pin settings");

	chk_busy_reject: assert property (
		(rd_evt && !q_q.boot_done) |=> !q_q.rvalid ##1 $stable(q_q.rvalid) || rd_evt)
		else $error("read answered before boot done");

	chk_busy_nowrite: assert property (
		(wr_evt && !q_q.boot_done && !q_q.hib_s2) |=> $stable(q_q.pol) && $stable(q_q.mag_en))
		else $error("write accepted before boot done");

	chk_temp_latch: assert property (
		(sample_strobe && !restart) |=>
			q_q.drdy && q_q.temp == $past(temp_celsius) - TEMP_REF_C)
		else $error("temperature not latched with sample flag");

	chk_mag_gate: assert property (
		(sample_strobe && !q_q.mag_en && !restart) |=> $stable(q_q.mag))
		else $error("magnitude updated while disabled");

	chk_drdy_clear: assert property (
		(rd_evt && q_q.boot_done && lnk.addr == A_MAG_HI && !sample_strobe && !restart)
			|=> !q_q.drdy)
		else $error("magnitude read left sample flag set");

	chk_mag_hi_byte: assert property (
		(rd_evt && q_q.boot_done && lnk.addr == A_MAG_HI && !q_q.byte_order && !restart)
			|=> q_q.rdata == {4'h0, $past(mag_hi)})
		else $error("high magnitude byte wrong");

	chk_mag_lo_byte: assert property (
		(rd_evt && q_q.boot_done && lnk.addr == A_MAG_LO && !q_q.byte_order && !restart)
			|=> q_q.rdata == $past(mag_lo))
		else $error("low magnitude byte wrong");

	chk_done_holds: assert property (
		(q_q.boot_done && !restart) |=> q_q.boot_done)
		else $error("boot done dropped without reset event");

	cov_strap_high_pulse: cover property (q_q.strap && q_q.state == BPT_PULSE);
	cov_route_second: cover property (!q_q.strap && q_q.route2 && q_q.state == BPT_PULSE);
	cov_drdy_read_clear: cover property (q_q.drdy ##1 rd_evt ##1 !q_q.drdy);
	cov_soft_reset: cover property (soft_evt);

endmodule : bpt_regs

// ==== hdl/bpt_pkg.sv ====
/*
 * Shared constants for the boot pulse, temperature and magnitude register block:
 * register offsets, field positions, reset values, serial frame counts and timing.
 * Assumes a 100 MHz core clock; long counts are overridable at the top level.
 */
package bpt_pkg;

	// core clock rate and boot timing
	localparam int CLK_MHZ = 100;
	localparam int BOOT_SHORT_US = 2;
	localparam int BOOT_SHORT_CYC = BOOT_SHORT_US * CLK_MHZ;
	localparam int BOOT_LONG_MS = 1;
	localparam int BOOT_LONG_CYC = BOOT_LONG_MS * 1000 * CLK_MHZ;
	localparam int BOOT_SEQ_CYC = 64;
	localparam int CNT_W = 20;

	// register offsets (7-bit serial address)
	localparam logic [6:0] A_STATUS = 7'h00;
	localparam logic [6:0] A_TEMP = 7'h01;
	localparam logic [6:0] A_MAG_LO = 7'h02;
	localparam logic [6:0] A_MAG_HI = 7'h03;
	localparam logic [6:0] A_CFG_TWO = 7'h10;
	localparam logic [6:0] A_CFG_FOUR = 7'h12;
	localparam logic [6:0] A_CFG_FIVE = 7'h13;
	localparam logic [6:0] A_PIN_MAP = 7'h20;
	localparam logic [6:0] A_INT_EN = 7'h21;
	localparam logic [6:0] A_SOFT_RST = 7'h22;

	// field positions
	localparam int ST_BOOT_BIT = 0;
	localparam int ST_DRDY_BIT = 7;
	localparam int C2_ORDER_BIT = 0;
	localparam int C4_POL_BIT = 0;
	localparam int C4_OD_BIT = 1;
	localparam int C5_MAG_BIT = 0;
	localparam int PM_ROUTE_BIT = 0;
	localparam int IE_BOOT_BIT = 0;
	localparam int SR_GO_BIT = 0;

	// reset values
	localparam logic POL_RST = 1'b0;
	localparam logic OD_RST = 1'b0;
	localparam logic ROUTE_RST = 1'b0;
	localparam logic IEN_RST = 1'b0;
	localparam logic ORDER_RST = 1'b0;
	localparam logic MAGEN_RST = 1'b0;
	localparam logic PIN_OE_N_RST = 1'b1;

	// temperature offset: register zero means this many degrees
	localparam logic [7:0] TEMP_REF_C = 8'h19;

	// serial frame: rising-edge counts at which bytes complete
	localparam logic [4:0] SPI_CMD_END = 5'h07;
	localparam logic [4:0] SPI_DATA_END = 5'h0f;
	localparam logic [4:0] SPI_LAST = 5'h18;
	localparam int SPI_RW_BIT = 7;

	// boot sequencer, gray coded along booting, pulse, ready
	typedef enum logic [1:0] {
		BPT_BOOTING = 2'h0,
		BPT_PULSE = 2'h1,
		BPT_READY = 2'h3
	} bpt_boot_e;

endpackage : bpt_pkg

// ==== hdl/bpt_link_if.sv ====
/*
 * Signals between the serial link logic and the register core.
 * Requests are levels held until the frame ends; the core synchronises them.
 */
`timescale 1ns/1ps
interface bpt_link_if;
	logic rreq;
	logic wreq;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	modport link (output rreq, output wreq, output addr, output wdata,
		input rdata, input rvalid);
	modport core (input rreq, input wreq, input addr, input wdata,
		output rdata, output rvalid);
endinterface : bpt_link_if

// ==== hdl/bpt_spi_link.sv ====
/*
 * Serial slave frame logic clocked by the host serial clock.
 * Assumes chip select high between frames clears it, and sclk idles outside frames.
 */
`timescale 1ns/1ps
module bpt_spi_link (
	// serial pins
	input wire logic spi_sclk,
	input wire logic spi_csb_n,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe_n,
	// core side
	bpt_link_if.link lnk
);
	import bpt_pkg::*;

	typedef struct packed {
		logic [4:0] cnt;
		logic [7:0] sh;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic rreq;
		logic wreq;
		logic [7:0] out;
		logic oe;
	} bpt_lnk_s;

	bpt_lnk_s q_q;
	bpt_lnk_s q_d;

	// shift in on every rising edge; command byte, data byte, then read byte out
	always_comb begin
		q_d = q_q;
		q_d.sh = {q_q.sh[6:0], spi_mosi};
		q_d.out = {q_q.out[6:0], 1'b0};
		if (q_q.cnt != SPI_LAST) begin
			q_d.cnt = q_q.cnt + 5'h01;
		end
		if (q_q.cnt == SPI_CMD_END) begin
			q_d.rd = q_q.sh[SPI_RW_BIT - 1];
			q_d.addr = {q_q.sh[5:0], spi_mosi};
			q_d.rreq = q_q.sh[SPI_RW_BIT - 1];
		end
		if (q_q.cnt == SPI_DATA_END) begin
			if (q_q.rd) begin
				// core had a whole byte time to answer, so rdata is stable here
				q_d.out = lnk.rdata;
				q_d.oe = lnk.rvalid;
			end else begin
				q_d.wdata = {q_q.sh[6:0], spi_mosi};
				q_d.wreq = 1'b1;
			end
		end
	end

	// chip select ends the frame, since sclk may not run afterwards
	always_ff @(posedge spi_sclk or posedge spi_csb_n) begin
		if (spi_csb_n) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	// outputs
	assign spi_miso_o = q_q.out[7];
	assign spi_miso_oe_n = ~q_q.oe;
	assign lnk.rreq = q_q.rreq;
	assign lnk.wreq = q_q.wreq;
	assign lnk.addr = q_q.addr;
	assign lnk.wdata = q_q.wdata;

endmodule : bpt_spi_link

// ==== dv/bpt_host_model.sv ====
/*
 * Host side of the serial link: a mode 0 frame master with a task per frame.
 * Assumes a pull-up on the device data line, so a released line reads as ones.
 */
`timescale 1ns/1ps
module bpt_host_model (
	// serial pins
	output logic spi_sclk,
	output logic spi_csb_n,
	output logic spi_mosi,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe_n,
	// finished reads
	output logic [7:0] rd_byte,
	output int rd_count
);
	logic miso_line;

	// released line floats to the pull-up level
	assign miso_line = spi_miso_oe_n ? 1'b1 : spi_miso_o;

	initial begin
		spi_sclk = 1'b0;
		spi_csb_n = 1'b0;
		spi_mosi = 1'b0;
		rd_byte = 8'h00;
		rd_count = 0;
		// a real rise of chip select clears the link logic before the first frame
		#1;
		spi_csb_n = 1'b1;
	end

	// the link clock only runs inside frames; mosi moves after each falling edge
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd);
		logic [23:0] sh;
		logic [7:0] got;
		int n;
		sh = {rd, addr, wd, 8'h00};
		n = rd ? 24 : 16;
		got = 8'h00;
		#7;
		spi_csb_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi = sh[23 - i];
			#40;
			spi_sclk = 1'b1;
			if (i >= 16) got = {got[6:0], miso_line};
			#40;
			spi_sclk = 1'b0;
		end
		#40;
		spi_csb_n = 1'b1;
		// stale data is never left on the line after release
		spi_mosi = ~spi_mosi;
		if (rd) begin
			rd_byte = got;
			rd_count++;
		end
		#40;
	endtask : xfer
endmodule : bpt_host_model

// ==== dv/testbench.sv ====
/*
 * Self-checking bench for the boot pulse, temperature and magnitude registers.
 * Assumes the host model above and shortened boot pulse counts on the design.
 */
`timescale 1ns/1ps
module testbench;
	import bpt_pkg::*;
	localparam int SEQ_C = 200;
	localparam int SHORT_C = 20;
	localparam int LONG_C = 300;
	logic clock, reset, boot_mode_strap, hibernate, sample_strobe, boot_done;
	logic [7:0] temp_celsius, rd_byte;
	logic [11:0] magnitude_sample;
	logic spi_sclk, spi_csb_n, spi_mosi, spi_miso_o, spi_miso_oe_n;
	logic p1_o, p1_oe_n, p2_o, p2_oe_n, watch;
	logic [1:0] act_lvl;
	logic [31:0] lfsr;
	int rd_count, err_total, comparisons;
	int w1 = 0;
	int w2 = 0;
	logic [7:0] exp_rd[$];
	int exp_pw[$];

	bpt_regs #(.BOOT_SEQ_CYC_P(SEQ_C), .BOOT_SHORT_CYC_P(SHORT_C),
		.BOOT_LONG_CYC_P(LONG_C)) dut_u (
		.clock(clock), .reset(reset), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
		.spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n),
		.boot_mode_strap(boot_mode_strap), .hibernate(hibernate),
		.sample_strobe(sample_strobe), .temp_celsius(temp_celsius),
		.magnitude_sample(magnitude_sample), .first_interrupt_pin_o(p1_o),
		.first_interrupt_pin_oe_n(p1_oe_n), .second_interrupt_pin_o(p2_o),
		.second_interrupt_pin_oe_n(p2_oe_n), .boot_done(boot_done));

	bpt_host_model host_u (.spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_mosi(spi_mosi),
		.spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n), .rd_byte(rd_byte),
		.rd_count(rd_count));

	// core clock, 100 mhz
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_nx

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : check_byte

	// pulses are noted as pin * 1000 + width in clocks
	task automatic check_pulse(input int pin, input int w);
		int e;
		comparisons++;
		e = (exp_pw.size() != 0) ? exp_pw.pop_front() : 0;
		if (e != pin * 1000 + w) begin
			err_total++;
			$display("MISMATCH boot pulse expected %0d seen %0d", e, pin * 1000 + w);
		end
	endtask : check_pulse

	// each finished host read meets the oldest note
	always @(rd_count) begin
		check_byte("read data", (exp_rd.size() != 0) ? exp_rd.pop_front() : 8'hxx, rd_byte);
	end

	// pulse widths are only measured in boot windows, where settings are not moving;
	// pins are looked at on the falling edge, where they have settled
	always @(negedge clock) begin
		if (watch && p1_oe_n === 1'b0 && p1_o === act_lvl[0]) w1 <= w1 + 1;
		else if (w1 != 0) begin
			check_pulse(1, w1);
			w1 <= 0;
		end
		if (watch && p2_oe_n === 1'b0 && p2_o === act_lvl[1]) w2 <= w2 + 1;
		else if (w2 != 0) begin
			check_pulse(2, w2);
			w2 <= 0;
		end
	end

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		host_u.xfer(1'b1, a, 8'h00);
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.xfer(1'b0, a, d);
	endtask : wr

	task automatic wait_boot(input int extra);
		int n;
		n = 0;
		while (boot_done !== 1'b1 && n < 5000) begin
			@(negedge clock);
			n++;
		end
		check_byte("boot done", 8'h01, {7'h00, boot_done});
		if (n >= 5000) complete_run();
		repeat (extra) @(negedge clock);
	endtask : wait_boot

	task automatic sample();
		lfsr = lfsr_nx(lfsr);
		@(negedge clock);
		sample_strobe = 1'b1;
		temp_celsius = lfsr[7:0];
		magnitude_sample = lfsr[19:8];
		@(negedge clock);
		sample_strobe = 1'b0;
		rd(A_STATUS, 8'h81);
		rd(A_TEMP, temp_celsius - TEMP_REF_C);
	endtask : sample

	// a hang anywhere ends the run as a failure
	initial begin
		#500us;
		err_total++;
		$display("MISMATCH run time expected end seen none");
		complete_run();
	end

	initial begin
		lfsr = 32'h00016fb4;
		reset = 1'b1;
		boot_mode_strap = 1'b0;
		hibernate = 1'b0;
		sample_strobe = 1'b0;
		temp_celsius = 8'h00;
		magnitude_sample = 12'h000;
		watch = 1'b0;
		act_lvl = 2'b01;
		err_total = 0;
		comparisons = 0;
		repeat (6) @(negedge clock);
		reset = 1'b0;
		rd(A_STATUS, 8'hff);
		wait_boot(4);
		rd(A_STATUS, 8'h01);
		rd(7'h7f, 8'h00);
		// magnitude holds its reset value while disabled
		sample();
		rd(A_MAG_LO, 8'h00);
		rd(A_STATUS, 8'h01);
		rd(A_MAG_HI, 8'h00);
		wr(A_CFG_FIVE, 8'h01);
		for (int i = 0; i < 4; i++) begin
			if (i == 3) wr(A_CFG_TWO, 8'h01);
			sample();
			rd(A_MAG_HI, (i == 3) ? {magnitude_sample[3:0], 4'h0}
				: {4'h0, magnitude_sample[11:8]});
			rd(A_STATUS, 8'h01);
			rd(A_MAG_LO, (i == 3) ? magnitude_sample[11:4] : magnitude_sample[7:0]);
		end
		// settings written before a soft reset steer the next boot pulse; open drain, active low
		wr(A_CFG_FOUR, 8'h03);
		wr(A_PIN_MAP, 8'h01);
		wr(A_INT_EN, 8'h01);
		act_lvl = 2'b00;
		watch = 1'b1;
		exp_pw.push_back(2000 + SHORT_C);
		wr(A_SOFT_RST, 8'h01);
		wait_boot(SHORT_C + 20);
		watch = 1'b0;
		rd(A_MAG_LO, 8'h00);
		rd(A_CFG_FOUR, 8'h03);
		// hibernate clears polarity, and writes during boot are dropped
		hibernate = 1'b1;
		repeat (10) @(negedge clock);
		hibernate = 1'b0;
		wait_boot(2);
		wr(A_INT_EN, 8'h01);
		act_lvl = 2'b11;
		watch = 1'b1;
		exp_pw.push_back(1000 + SHORT_C);
		wr(A_SOFT_RST, 8'h01);
		wr(A_CFG_FOUR, 8'h01);
		wait_boot(SHORT_C + 20);
		watch = 1'b0;
		rd(A_CFG_FOUR, 8'h00);
		// strap high gives one long open-drain low pulse on pin two;
		// idle pins sit high first so a driven-low idle level is not taken for the pulse
		wr(A_CFG_FOUR, 8'h01);
		boot_mode_strap = 1'b1;
		act_lvl = 2'b00;
		watch = 1'b1;
		exp_pw.push_back(2000 + LONG_C);
		wr(A_SOFT_RST, 8'h01);
		wait_boot(LONG_C + 20);
		watch = 1'b0;
		check_byte("pin two release", 8'h01, {7'h00, p2_oe_n});
		check_byte("pulses left", 8'h00, 8'(exp_pw.size()));
		complete_run();
	end
endmodule : testbench
